// file: include/rsc_pkg.sv
// Notes on behaviour
// RQ1: any listed source asserts internal reset
// RQ2: programming exit acts like power-on
// RQ3: optional power-up timer extends reset
// RQ4: debounced undervoltage resets, clears brownout flag
// RQ5: mode 11: always on, start waits ready
// RQ6: mode 10: off in sleep, wake waits
// RQ7: mode 01: software enable, no start wait
// RQ8: ready flag shown; protection only when ready
// RQ9: mode 00: brownout disabled, enable ignored
// RQ10: mode 11 ready before execution starts
// RQ11: pin enabled if lvp or pin enable
// RQ12: pin reset clears pin cause flag
// RQ13: pin held low resets; glitches filtered
// RQ14: internal causes never drive pin low
// RQ15: disabled pin: software controls pull-up
// RQ16: watchdog reset updates timeout/powerdown/cause flags
// RQ17: reset instruction clears its cause flag
// RQ18: stack faults reset only when enabled
// RQ19: power-up timer up to 64 ms
// RQ20: execution starts 10 clocks after release
// RQ21: only matching flags change; writes never reset
// RQ22: internal reset released synchronously
package rsc_pkg;
   localparam int unsigned CLK_HZ       = 20_000_000;
   localparam int unsigned POWERUP_DELAY_TIMER_MS      = 64;
   localparam int unsigned POWERUP_DELAY_TIMER_CYC     = (CLK_HZ / 1000) * POWERUP_DELAY_TIMER_MS;
   localparam int unsigned DEBOUNCE_NS  = 1000;
   localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_NS + 49) / 50;
   localparam int unsigned PIN_FILT_CYC = 4;
   localparam int unsigned START_CYC    = 10;
   localparam logic [1:0] BO_OFF    = 2'h0;
   localparam logic [1:0] BO_SW     = 2'h1;
   localparam logic [1:0] BO_NOSLP  = 2'h2;
   localparam logic [1:0] BO_ALWAYS = 2'h3;
   // apb map
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_FLAGS  = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam int unsigned CTRL_SBOR_BIT = 0;
   localparam int unsigned CTRL_PUE_BIT  = 1;
   localparam logic [7:0] FLAGS_RST = 8'h3f;
   localparam logic       CTRL_SBOR_RST = 1'b1;
   // flag bits: timeout, powerdown, wdt, pin, instr, brownout, ovf, unf
   typedef struct packed {
      logic stack_under_flag;
      logic stack_over_flag;
      logic brownout_flag;
      logic instr_reset_cause_flag;
      logic pin_reset_cause_flag;
      logic watchdog_cause_flag;
      logic powerdown_flag;
      logic timeout_flag;
   } rsc_flags_t;
   typedef enum logic [3:0] {
      ST_POR  = 4'h1,
      ST_POWERUP_DELAY_TIMER = 4'h2,
      ST_WAIT = 4'h4,
      ST_RUN  = 4'h8
   } rsc_state_t;
   typedef struct packed {
      rsc_state_t state;
      logic [23:0] cnt;
      logic [7:0]  bo_cnt;
      logic [3:0]  pin_cnt;
      logic        pin_low;
      logic        sbor;
      logic        pue;
      rsc_flags_t  flags;
      logic        core_rst;
      logic [31:0] prdata;
   } rsc_st_t;
endpackage : rsc_pkg

// file: verilog/rsc_top.sv
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module rsc_top #(
   parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = rsc_pkg::POWERUP_DELAY_TIMER_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        por_event,
   input  wire logic        prog_exit,
   input  wire logic        vdd_below_bor,
   input  wire logic        bor_ready_in,
   input  wire logic        sleep_mode,
   input  wire logic        wake_req,
   input  wire logic [1:0]  brownout_mode_field,
   input  wire logic        powerup_delay_select,
   input  wire logic        pin_reset_enable,
   input  wire logic        low_voltage_prog_enable,
   input  wire logic        ext_reset_pin_i,
   output logic             ext_reset_pin_o,
   output logic             ext_reset_pin_oe,
   output logic             pin_pullup_en,
   input  wire logic        watchdog_timeout,
   input  wire logic        watchdog_clear_instr,
   input  wire logic        sleep_instr,
   input  wire logic        reset_instr,
   input  wire logic        stack_fault_reset_enable,
   input  wire logic        stack_over,
   input  wire logic        stack_under,
   output logic             brownout_ready_flag,
   output logic             brownout_armed,
   output logic             core_reset,
   output logic             wake_ok
);
   rsc_pkg::rsc_st_t s_ff;
   rsc_pkg::rsc_st_t nxt_s;
   logic bo_active;
   logic bo_trip;
   logic pin_en;
   logic pin_rst;
   logic cold;
   logic warm;
   logic wr;
   logic rd;

   // apb strobes, zero wait states
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign prdata  = s_ff.prdata;

   // brownout detector mode decode
   always_comb begin
      case (brownout_mode_field)
         rsc_pkg::BO_ALWAYS: bo_active = 1'b1;            // RQ5
         rsc_pkg::BO_NOSLP:  bo_active = ~sleep_mode;     // RQ6
         rsc_pkg::BO_SW:     bo_active = s_ff.sbor;       // RQ7
         default:            bo_active = 1'b0;            // RQ9
      endcase
   end
   assign brownout_ready_flag = bo_active & bor_ready_in; // RQ8
   assign brownout_armed      = brownout_ready_flag;
   assign bo_trip = brownout_ready_flag &&
                    s_ff.bo_cnt >= 8'(rsc_pkg::DEBOUNCE_CYC); // RQ4

   // pin function and filter
   assign pin_en  = low_voltage_prog_enable | pin_reset_enable; // RQ11
   assign pin_rst = pin_en & s_ff.pin_low;                      // RQ13
   assign ext_reset_pin_o  = 1'b0;  // RQ14
   assign ext_reset_pin_oe = 1'b0;  // RQ14
   assign pin_pullup_en = pin_en ? 1'b1 : s_ff.pue; // RQ15

   assign cold = por_event | prog_exit | bo_trip; // RQ1 RQ2
   assign warm = watchdog_timeout | reset_instr | pin_rst |
                 (stack_fault_reset_enable & (stack_over | stack_under)); // RQ18
   assign core_reset = s_ff.core_rst; // RQ22
   // wake gating: mode 10 waits for ready and supply, others immediate
   assign wake_ok = wake_req &
      ((brownout_mode_field != rsc_pkg::BO_NOSLP) ||
       (bor_ready_in & ~vdd_below_bor)); // RQ6

   // next state
   always_comb begin
      nxt_s = s_ff;
      nxt_s.prdata = 32'h0;
      nxt_s.bo_cnt = (brownout_ready_flag & vdd_below_bor) ?
         (s_ff.bo_cnt == 8'hff ? 8'hff : s_ff.bo_cnt + 8'h1) : 8'h0;
      if ((~ext_reset_pin_i) == s_ff.pin_low) // pin matches filtered level
         nxt_s.pin_cnt = 4'h0;
      else if (s_ff.pin_cnt == 4'(rsc_pkg::PIN_FILT_CYC - 1)) begin
         nxt_s.pin_low = ~ext_reset_pin_i; // RQ13
         nxt_s.pin_cnt = 4'h0;
      end else
         nxt_s.pin_cnt = s_ff.pin_cnt + 4'h1;
      // software access; writes never start a reset
      if (wr && paddr == rsc_pkg::ADDR_CTRL) begin
         nxt_s.sbor = pwdata[rsc_pkg::CTRL_SBOR_BIT];
         nxt_s.pue  = pwdata[rsc_pkg::CTRL_PUE_BIT];
      end
      if (wr && paddr == rsc_pkg::ADDR_FLAGS)
         nxt_s.flags = pwdata[7:0]; // RQ21
      if (rd) begin
         case (paddr)
            rsc_pkg::ADDR_CTRL:   nxt_s.prdata = {30'h0, s_ff.pue, s_ff.sbor};
            rsc_pkg::ADDR_FLAGS:  nxt_s.prdata = {24'h0, s_ff.flags};
            rsc_pkg::ADDR_STATUS: nxt_s.prdata = {28'h0, s_ff.state};
            default:              nxt_s.prdata = 32'h0;
         endcase
      end
      // sleep and clear instructions move timeout and powerdown
      if (watchdog_clear_instr) begin
         nxt_s.flags.timeout_flag   = 1'b1;
         nxt_s.flags.powerdown_flag = 1'b1;
      end
      if (sleep_instr) begin
         nxt_s.flags.timeout_flag   = 1'b1;
         nxt_s.flags.powerdown_flag = 1'b0;
      end
      // hardware events beat software writes
      if (watchdog_timeout) begin
         nxt_s.flags.timeout_flag        = 1'b0; // RQ16
         nxt_s.flags.watchdog_cause_flag = 1'b0; // RQ16
         if (sleep_mode)
            nxt_s.flags.powerdown_flag = 1'b0;   // RQ16
      end
      if (pin_rst) begin
         nxt_s.flags.pin_reset_cause_flag = 1'b0; // RQ12
         if (sleep_mode) begin
            nxt_s.flags.timeout_flag   = 1'b1;
            nxt_s.flags.powerdown_flag = 1'b0;
         end
      end
      if (reset_instr)
         nxt_s.flags.instr_reset_cause_flag = 1'b0; // RQ17
      if (stack_fault_reset_enable & stack_over)
         nxt_s.flags.stack_over_flag = 1'b1;  // RQ18
      if (stack_fault_reset_enable & stack_under)
         nxt_s.flags.stack_under_flag = 1'b1; // RQ18
      if (bo_trip) begin
         nxt_s.flags = rsc_pkg::FLAGS_RST;
         nxt_s.flags.brownout_flag = 1'b0; // RQ4
      end
      if (por_event | prog_exit) begin
         nxt_s.flags = rsc_pkg::FLAGS_RST; // RQ2
         nxt_s.sbor  = rsc_pkg::CTRL_SBOR_RST;
      end
      // sequencer
      case (s_ff.state)
         rsc_pkg::ST_POR: begin
            nxt_s.core_rst = 1'b1;
            nxt_s.cnt = 24'h0;
            if (!cold)
               nxt_s.state = powerup_delay_select ?
                  rsc_pkg::ST_POWERUP_DELAY_TIMER : rsc_pkg::ST_WAIT; // RQ3
         end
         rsc_pkg::ST_POWERUP_DELAY_TIMER: begin
            nxt_s.cnt = s_ff.cnt + 24'h1;
            if (s_ff.cnt >= 24'(POWERUP_DELAY_TIMER_CYCLES - 1)) begin // RQ19
               nxt_s.cnt = 24'h0;
               nxt_s.state = rsc_pkg::ST_WAIT;
            end
         end
         rsc_pkg::ST_WAIT: begin
            // mode 11 start waits for ready and supply
            if (pin_rst || (brownout_mode_field == rsc_pkg::BO_ALWAYS &&
                (!bor_ready_in || vdd_below_bor)))       // RQ5 RQ10
               nxt_s.cnt = 24'h0;
            else if (s_ff.cnt == 24'(rsc_pkg::START_CYC - 1)) begin // RQ20
               nxt_s.core_rst = 1'b0; // RQ22
               nxt_s.state = rsc_pkg::ST_RUN;
            end else
               nxt_s.cnt = s_ff.cnt + 24'h1;
         end
         rsc_pkg::ST_RUN: begin
            if (warm) begin // RQ1
               nxt_s.core_rst = 1'b1;
               nxt_s.cnt = 24'h0;
               nxt_s.state = rsc_pkg::ST_WAIT;
            end
         end
         default: nxt_s.state = rsc_pkg::ST_POR;
      endcase
      if (cold) begin // RQ1
         nxt_s.core_rst = 1'b1;
         nxt_s.state = rsc_pkg::ST_POR;
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff.state    <= rsc_pkg::ST_POR;
         s_ff.cnt      <= 24'h0;
         s_ff.bo_cnt   <= 8'h0;
         s_ff.pin_cnt  <= 4'h0;
         s_ff.pin_low  <= 1'b0;
         s_ff.sbor     <= rsc_pkg::CTRL_SBOR_RST;
         s_ff.pue      <= 1'b0;
         s_ff.flags    <= rsc_pkg::FLAGS_RST;
         s_ff.core_rst <= 1'b1;
         s_ff.prdata   <= 32'h0;
      end else
         s_ff <= nxt_s;
   end

   // checks
   property p_ext_pin_never_driven;
      @(posedge pclk) disable iff (!presetn) !ext_reset_pin_oe;
   endproperty
   a_ext_pin_never_driven: assert property (p_ext_pin_never_driven) // RQ14
      else $error("reset pin driven");
   property p_cold_holds;
      @(posedge pclk) disable iff (!presetn) cold |=> core_reset;
   endproperty
   a_cold_holds: assert property (p_cold_holds) // RQ1
      else $error("cold source did not reset");
   property p_warm_resets;
      @(posedge pclk) disable iff (!presetn)
         (s_ff.state == rsc_pkg::ST_RUN && warm) |=> core_reset;
   endproperty
   a_warm_resets: assert property (p_warm_resets) // RQ1
      else $error("warm source did not reset");
   property p_instr_flag;
      @(posedge pclk) disable iff (!presetn)
         reset_instr && !cold |=> !s_ff.flags.instr_reset_cause_flag;
   endproperty
   a_instr_flag: assert property (p_instr_flag) // RQ17
      else $error("instr flag not cleared");
   property p_pin_flag;
      @(posedge pclk) disable iff (!presetn)
         pin_rst && !cold |=> !s_ff.flags.pin_reset_cause_flag;
   endproperty
   a_pin_flag: assert property (p_pin_flag) // RQ12
      else $error("pin flag not cleared");
   property p_wdt_flag;
      @(posedge pclk) disable iff (!presetn)
         watchdog_timeout && !cold |=>
            !s_ff.flags.timeout_flag && !s_ff.flags.watchdog_cause_flag;
   endproperty
   a_wdt_flag: assert property (p_wdt_flag) // RQ16
      else $error("watchdog flags wrong");
   property p_bo_off;
      @(posedge pclk) disable iff (!presetn)
         brownout_mode_field == rsc_pkg::BO_OFF |-> !brownout_ready_flag;
   endproperty
   a_bo_off: assert property (p_bo_off) // RQ9
      else $error("brownout active in mode 00");
   sequence s_released;
      s_ff.state == rsc_pkg::ST_WAIT ##1 s_ff.state == rsc_pkg::ST_RUN;
   endsequence
   property p_start_delay;
      @(posedge pclk) disable iff (!presetn)
         s_released |-> $past(s_ff.cnt) == 24'(rsc_pkg::START_CYC - 1);
   endproperty
   a_start_delay: assert property (p_start_delay) // RQ20
      else $error("start delay wrong");
   property p_stack_gate;
      @(posedge pclk) disable iff (!presetn)
         (s_ff.state == rsc_pkg::ST_RUN && !stack_fault_reset_enable &&
          !watchdog_timeout && !reset_instr && !pin_rst && !cold)
            |=> !core_reset;
   endproperty
   a_stack_gate: assert property (p_stack_gate) // RQ18
      else $error("unexpected reset");
   // cause flags, start-up sequencing, wake gating, detector modes, pin and writes
   property p_bo_flag;
      @(posedge pclk) disable iff (!presetn)
         bo_trip && !por_event && !prog_exit |=> !s_ff.flags.brownout_flag;
   endproperty
   a_bo_flag: assert property (p_bo_flag) // RQ4
      else $error("brownout flag not cleared");
   property p_prog_exit;
      @(posedge pclk) disable iff (!presetn)
         prog_exit |=> core_reset && s_ff.flags == rsc_pkg::FLAGS_RST;
   endproperty
   a_prog_exit: assert property (p_prog_exit) // RQ2
      else $error("programming exit unlike power-on");
   property p_powerup_delay_timer_on;
      @(posedge pclk) disable iff (!presetn)
         s_ff.state == rsc_pkg::ST_POR && !cold && powerup_delay_select
            |=> s_ff.state == rsc_pkg::ST_POWERUP_DELAY_TIMER;
   endproperty
   a_powerup_delay_timer_on: assert property (p_powerup_delay_timer_on) // RQ3
      else $error("power-up timer not started");
   property p_powerup_delay_timer_off;
      @(posedge pclk) disable iff (!presetn)
         s_ff.state == rsc_pkg::ST_POR && !cold && !powerup_delay_select
            |=> s_ff.state == rsc_pkg::ST_WAIT;
   endproperty
   a_powerup_delay_timer_off: assert property (p_powerup_delay_timer_off) // RQ3
      else $error("power-up timer not skipped");
   property p_powerup_delay_timer_len;
      @(posedge pclk) disable iff (!presetn)
         s_ff.state == rsc_pkg::ST_POWERUP_DELAY_TIMER && !cold &&
         s_ff.cnt < 24'(POWERUP_DELAY_TIMER_CYCLES - 1)
            |=> s_ff.state == rsc_pkg::ST_POWERUP_DELAY_TIMER && core_reset;
   endproperty
   a_powerup_delay_timer_len: assert property (p_powerup_delay_timer_len) // RQ19
      else $error("power-up timer ended early");
   property p_start_ready;
      @(posedge pclk) disable iff (!presetn)
         s_ff.state == rsc_pkg::ST_WAIT && !cold && !bor_ready_in &&
         brownout_mode_field == rsc_pkg::BO_ALWAYS
            |=> core_reset && s_ff.cnt == 24'h0;
   endproperty
   a_start_ready: assert property (p_start_ready) // RQ5
      else $error("start did not wait for detector");
   property p_wake_hold;
      @(posedge pclk) disable iff (!presetn)
         brownout_mode_field == rsc_pkg::BO_NOSLP &&
         (!bor_ready_in || vdd_below_bor) |-> !wake_ok;
   endproperty
   a_wake_hold: assert property (p_wake_hold) // RQ6
      else $error("wake not held off");
   property p_wake_now;
      @(posedge pclk) disable iff (!presetn)
         brownout_mode_field == rsc_pkg::BO_ALWAYS |-> wake_ok == wake_req;
   endproperty
   a_wake_now: assert property (p_wake_now) // RQ5
      else $error("wake delayed in always-on mode");
   property p_sw_off;
      @(posedge pclk) disable iff (!presetn)
         brownout_mode_field == rsc_pkg::BO_SW && !s_ff.sbor
            |-> !brownout_ready_flag;
   endproperty
   a_sw_off: assert property (p_sw_off) // RQ7
      else $error("software disable ignored");
   property p_ready_gate;
      @(posedge pclk) disable iff (!presetn)
         !bor_ready_in |-> !brownout_ready_flag && !bo_trip;
   endproperty
   a_ready_gate: assert property (p_ready_gate) // RQ8
      else $error("protection before ready");
   property p_pullup;
      @(posedge pclk) disable iff (!presetn)
         !low_voltage_prog_enable && !pin_reset_enable
            |-> pin_pullup_en == s_ff.pue && !pin_rst;
   endproperty
   a_pullup: assert property (p_pullup) // RQ15
      else $error("disabled pin not under software");
   property p_pin_filter;
      @(posedge pclk) disable iff (!presetn)
         s_ff.pin_cnt < 4'(rsc_pkg::PIN_FILT_CYC - 1)
            |=> $stable(s_ff.pin_low);
   endproperty
   a_pin_filter: assert property (p_pin_filter) // RQ13
      else $error("pin glitch passed filter");
   property p_wait_pin;
      @(posedge pclk) disable iff (!presetn)
         s_ff.state == rsc_pkg::ST_WAIT && pin_rst && !cold
            |=> core_reset && s_ff.cnt == 24'h0;
   endproperty
   a_wait_pin: assert property (p_wait_pin) // RQ20
      else $error("start count ran with pin low");
   sequence s_freed;
      $fell(core_reset);
   endsequence
   property p_sync_release;
      @(posedge pclk) disable iff (!presetn)
         s_freed |-> $past(s_ff.state) == rsc_pkg::ST_WAIT;
   endproperty
   a_sync_release: assert property (p_sync_release) // RQ22
      else $error("reset released outside sequencer");
   property p_sw_no_reset;
      @(posedge pclk) disable iff (!presetn)
         s_ff.state == rsc_pkg::ST_RUN && wr && !warm && !cold
            |=> !core_reset;
   endproperty
   a_sw_no_reset: assert property (p_sw_no_reset) // RQ21
      else $error("register write caused reset");
   property p_stack_flag;
      @(posedge pclk) disable iff (!presetn)
         stack_fault_reset_enable && stack_over && !cold
            |=> s_ff.flags.stack_over_flag;
   endproperty
   a_stack_flag: assert property (p_stack_flag) // RQ18
      else $error("overflow flag not set");
endmodule : rsc_top

// file: sim/rsc_pin_model.sv
`timescale 1ns/1ps
module rsc_pin_model (
   input  wire logic pclk,
   output logic      ext_reset_pin_i,
   output logic      vdd_below_bor,
   output logic      bor_ready_in
);
   logic pin_low_ff = 1'b0;
   // weak pull-up takes the pin high whenever nobody holds it low
   assign ext_reset_pin_i = ~pin_low_ff;
   // supply starts healthy with the detector warmed up
   initial begin
      vdd_below_bor = 1'b0;
      bor_ready_in  = 1'b1;
   end
   // hold the pin low for n clocks, then let go
   task automatic pin_low(input int n);
      pin_low_ff <= 1'b1;
      repeat (n) @(posedge pclk);
      pin_low_ff <= 1'b0;
   endtask : pin_low
   // supply sags below threshold for n clocks
   task automatic dip(input int n);
      vdd_below_bor <= 1'b1;
      repeat (n) @(posedge pclk);
      vdd_below_bor <= 1'b0;
   endtask : dip
   // detector ready level
   task automatic ready(input logic v);
      bor_ready_in <= v;
   endtask : ready
endmodule : rsc_pin_model

// file: sim/reset_source_controller_test.sv
`timescale 1ns/1ps
module reset_source_controller_test;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        por_event, prog_exit, sleep_mode, wake_req, wake_ok;
   logic        powerup_delay_select, pin_reset_enable;
   logic        low_voltage_prog_enable, ext_reset_pin_i;
   logic        ext_reset_pin_o, ext_reset_pin_oe, pin_pullup_en;
   logic        watchdog_timeout, watchdog_clear_instr, sleep_instr;
   logic        reset_instr, stack_fault_reset_enable, stack_over;
   logic        stack_under, brownout_ready_flag, brownout_armed;
   logic        core_reset, vdd_below_bor, bor_ready_in;
   logic [1:0]  brownout_mode_field;
   int          errors = 0;
   int          compares = 0;
   // free-running bus clock
   always #25 pclk = ~pclk;
   rsc_top #(.POWERUP_DELAY_TIMER_CYCLES(20)) dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .por_event, .prog_exit,
      .vdd_below_bor, .bor_ready_in, .sleep_mode, .wake_req,
      .brownout_mode_field, .powerup_delay_select, .pin_reset_enable,
      .low_voltage_prog_enable, .ext_reset_pin_i, .ext_reset_pin_o,
      .ext_reset_pin_oe, .pin_pullup_en, .watchdog_timeout,
      .watchdog_clear_instr, .sleep_instr, .reset_instr,
      .stack_fault_reset_enable, .stack_over, .stack_under,
      .brownout_ready_flag, .brownout_armed, .core_reset, .wake_ok
   );
   rsc_pin_model mdl (.pclk, .ext_reset_pin_i, .vdd_below_bor,
                      .bor_ready_in);
   task automatic tk(input int n);
      repeat (n) @(posedge pclk);
   endtask : tk
   task automatic cmp(input string w, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", w, e, g);
      end
   endtask : cmp
   task automatic cmp_bit(input string w, input logic e, input logic g);
      cmp(w, {31'h0, e}, {31'h0, g});
   endtask : cmp_bit
   // one apb transfer, held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] r);
      int n;
      n = 0;
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
      r = prdata;
      {psel, penable} <= 2'b00;
      tk(1);
   endtask : apb
   // look at core reset between edges
   task automatic chk_rst(input logic e);
      @(negedge pclk);
      cmp_bit("core_reset", e, core_reset);
      @(posedge pclk);
   endtask : chk_rst
   task automatic wait_run(input int lim);
      int n;
      n = 0;
      while (core_reset !== 1'b0 && n++ < lim) @(negedge pclk);
      cmp_bit("core_reset released", 1'b0, core_reset);
      @(posedge pclk);
   endtask : wait_run
   task automatic flags(input logic [7:0] e, input logic [7:0] m);
      apb(1'b0, rsc_pkg::ADDR_FLAGS, 32'h0, rd);
      cmp("flags", {24'h0, e}, rd & {24'h0, m});
   endtask : flags
   task automatic set_flags(input logic [7:0] v);
      apb(1'b1, rsc_pkg::ADDR_FLAGS, {24'h0, v}, rd);
   endtask : set_flags
   task automatic t_pin();
      mdl.pin_low(2);
      chk_rst(1'b0);
      mdl.pin_low(8);
      chk_rst(1'b1);
      cmp_bit("pin_drive", 1'b0, ext_reset_pin_oe | ext_reset_pin_o);
      tk(7);
      chk_rst(1'b1);
      wait_run(40);
      flags(8'h37, 8'hff);
      {pin_reset_enable, low_voltage_prog_enable} <= 2'b00;
      apb(1'b1, rsc_pkg::ADDR_CTRL, 32'h3, rd);
      cmp_bit("pullup", 1'b1, pin_pullup_en);
      mdl.pin_low(8);
      chk_rst(1'b0);
      low_voltage_prog_enable <= 1'b1;
      mdl.pin_low(8);
      chk_rst(1'b1);
      wait_run(40);
   endtask : t_pin
   // warm source: 0 watchdog, 1 reset instr, 2 overflow, 3 underflow
   task automatic t_warm(input int k, input logic r, input logic [7:0] e);
      set_flags(8'h3f);
      case (k)
         0: watchdog_timeout <= 1'b1;
         1: reset_instr <= 1'b1;
         2: stack_over <= 1'b1;
         default: stack_under <= 1'b1;
      endcase
      tk(1);
      {watchdog_timeout, reset_instr, stack_over, stack_under} <= 4'h0;
      tk(1);
      chk_rst(r);
      wait_run(40);
      if (r) flags(e, 8'hff);
   endtask : t_warm
   task automatic t_bo();
      brownout_mode_field <= rsc_pkg::BO_OFF;
      mdl.dip(30);
      chk_rst(1'b0);
      cmp_bit("ready_off", 1'b0, brownout_ready_flag);
      brownout_mode_field <= rsc_pkg::BO_SW;
      apb(1'b1, rsc_pkg::ADDR_CTRL, 32'h2, rd);
      mdl.dip(30);
      chk_rst(1'b0);
      brownout_mode_field <= rsc_pkg::BO_ALWAYS;
      set_flags(8'h3f);
      mdl.dip(10);
      chk_rst(1'b0);
      mdl.dip(30);
      chk_rst(1'b1);
      wait_run(200);
      flags(8'h1f, 8'hff);
      cmp_bit("ready_on", 1'b1, brownout_ready_flag);
      {sleep_mode, wake_req} <= 2'b11;
      brownout_mode_field <= rsc_pkg::BO_NOSLP;
      mdl.ready(1'b0);
      chk_rst(1'b0);
      cmp_bit("wake_hold", 1'b0, wake_ok);
      mdl.ready(1'b1);
      tk(1);
      cmp_bit("wake_go", 1'b1, wake_ok);
      brownout_mode_field <= rsc_pkg::BO_ALWAYS;
      mdl.ready(1'b0);
      tk(1);
      cmp_bit("wake_now", 1'b1, wake_ok);
      {sleep_mode, wake_req} <= 2'b00;
      mdl.ready(1'b1);
   endtask : t_bo
   // power-on without timer, start held until detector ready
   task automatic t_por();
      powerup_delay_select <= 1'b0;
      mdl.ready(1'b0);
      por_event <= 1'b1;
      tk(2);
      por_event <= 1'b0;
      tk(15);
      chk_rst(1'b1);
      mdl.ready(1'b1);
      tk(8);
      chk_rst(1'b1);
      wait_run(20);
      powerup_delay_select <= 1'b1;
   endtask : t_por
   // sleep and clear instructions, bus status outputs
   task automatic t_instr();
      set_flags(8'h00);
      sleep_instr <= 1'b1;
      tk(1);
      sleep_instr <= 1'b0;
      flags(8'h01, 8'h03);
      watchdog_clear_instr <= 1'b1;
      tk(1);
      watchdog_clear_instr <= 1'b0;
      flags(8'h03, 8'h03);
      cmp_bit("pready", 1'b1, pready);
      cmp_bit("pslverr", 1'b0, pslverr);
      cmp_bit("armed", 1'b1, brownout_armed);
      cmp_bit("pin_out", 1'b0, ext_reset_pin_o);
   endtask : t_instr
   task automatic tally_and_finish();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {por_event, prog_exit, sleep_mode, wake_req} = '0;
      {powerup_delay_select, pin_reset_enable} = 2'b11;
      {low_voltage_prog_enable, watchdog_timeout} = '0;
      {watchdog_clear_instr, sleep_instr, reset_instr} = '0;
      {stack_fault_reset_enable, stack_over, stack_under} = '0;
      brownout_mode_field = rsc_pkg::BO_ALWAYS;
      tk(16);
      presetn <= 1'b1;
      tk(25);
      chk_rst(1'b1);
      wait_run(100);
      flags(8'h3f, 8'hff);
      apb(1'b0, rsc_pkg::ADDR_STATUS, 32'h0, rd);
      cmp("status", 32'h8, rd);
      apb(1'b0, 12'h00c, 32'h0, rd);
      cmp("unmapped", 32'h0, rd);
      set_flags(8'h00);
      chk_rst(1'b0);
      set_flags(8'h3f);
      t_pin();
      t_warm(0, 1'b1, 8'h3a);
      t_warm(1, 1'b1, 8'h2f);
      t_warm(2, 1'b0, 8'h00);
      stack_fault_reset_enable <= 1'b1;
      t_warm(2, 1'b1, 8'h7f);
      t_warm(3, 1'b1, 8'hbf);
      t_bo();
      t_por();
      t_instr();
      set_flags(8'h00);
      prog_exit <= 1'b1;
      tk(4);
      prog_exit <= 1'b0;
      chk_rst(1'b1);
      wait_run(200);
      flags(8'h1f, 8'hdf);
      tally_and_finish();
   end
   // hang guard
   initial begin
      #(20000 * 50);
      errors++;
      tally_and_finish();
   end
endmodule : reset_source_controller_test
